// *** verilog/ext_irq_cfg.svh ***
`ifndef EXT_IRQ_CFG_SVH
`define EXT_IRQ_CFG_SVH

// source counts
`define EXT_SRC_COUNT    4
`define SRC_COUNT        5
`define SRC_IDX_W        3

// segment qualifiers
`define SEG_IO_SPACE     1'b1
`define SEG_KEY_PRIV     1'b1
`define BUS_UNIT_ZERO    8'h00
`define ADAPTER_ZERO     20'h00000

// register offsets within the segment
`define OFF_MASK_LO      28'h0000000
`define OFF_MASK_HI      28'h0000004
`define OFF_RSVD_A       28'h0000008
`define OFF_RSVD_B       28'h000000c
`define OFF_SUM_LO       28'h0000010
`define OFF_SUM_HI       28'h0000014
`define OFF_RSVD_C       28'h0000018
`define OFF_RSVD_D       28'h000001c
`define OFF_TIMER_SEL    28'h0000020
`define OFF_SRC_SEL_BASE 28'h0000040
`define OFF_SRC_SEL_END  28'h0000050

// address fields
`define ADDR_ALIGN_HI    1
`define ADDR_ALIGN_LO    0
`define ADDR_WORD_BIT    2
`define ADDR_IDX_SHIFT   2
`define WORD_BITS        32

// selector field in a data word
`define SEL_FIELD_HI     5
`define SEL_FIELD_LO     0
`define SEL_PAD_W        26

// source index of the countdown timer
`define TIMER_SRC_IDX    3'h0
`define EXT_SRC_IDX0     3'h1

`endif

// *** verilog/ext_irq_pkg.sv ***
package ext_irq_pkg;

  // big-endian numbering: bit 0 is the msb of the low word
  typedef logic [0:63]  vec64_t;
  typedef logic [5:0]   sel_t;
  typedef logic [27:0]  io_addr_t;
  typedef logic [31:0]  word_t;

  typedef enum {
    ACC_IDLE,
    ACC_BURST,
    ACC_ABORT
  } acc_state_t;

endpackage : ext_irq_pkg

// *** verilog/sel_map_if.sv ***
`timescale 1ns/100ps
`include "ext_irq_cfg.svh"

interface sel_map_if;
  import ext_irq_pkg::*;

  logic [`SRC_COUNT-1:0] sel_wr;
  sel_t                  sel_wdata;
  sel_t                  sel_rdata [`SRC_COUNT];
  logic [`SRC_COUNT-1:0] src_evt;
  vec64_t                set_vec;

  modport ctrl (
    output sel_wr,
    output sel_wdata,
    output src_evt,
    input  sel_rdata,
    input  set_vec
  );

  modport map (
    input  sel_wr,
    input  sel_wdata,
    input  src_evt,
    output sel_rdata,
    output set_vec
  );

endinterface : sel_map_if

// *** verilog/source_mapper.sv ***
`timescale 1ns/100ps
`include "ext_irq_cfg.svh"

module source_mapper (
  // clock and reset
  input  wire logic  core_clk_i,
  input  wire logic  rst_b_i,
  // selector and event link
  sel_map_if.map     map_io
);
  import ext_irq_pkg::*;

  vec64_t hit [`SRC_COUNT];

  genvar g;
  generate
    for (g = 0; g < `SRC_COUNT; g++) begin : g_src
      sel_t sel_reg;

      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          sel_reg <= '0;
        end else if (map_io.sel_wr[g]) begin
          sel_reg <= map_io.sel_wdata; // RULE_19
        end
      end

      assign map_io.sel_rdata[g] = sel_reg;

      always_comb begin
        hit[g] = '0;
        if (map_io.src_evt[g]) begin
          hit[g][sel_reg] = 1'b1; // RULE_20
        end
      end
    end
  endgenerate

  // or of all source hits
  always_comb begin
    map_io.set_vec = '0;
    for (int i = 0; i < `SRC_COUNT; i++) begin
      map_io.set_vec = map_io.set_vec | hit[i];
    end
  end

endmodule : source_mapper

// *** verilog/ext_irq_mask_summary.sv ***
`timescale 1ns/100ps
`include "ext_irq_cfg.svh"

// Overview of operation
// RULE_01 - irq only when enable set and combined
// RULE_02 - mask and summary both 64 bits
// RULE_03 - mask one enables, zero ignores bit
// RULE_04 - source sets summary bit regardless of mask
// RULE_05 - combined true when set bit unmasked
// RULE_06 - io segment, unit zero, key one faults
// RULE_07 - reserved location faults, earlier writes kept
// RULE_08 - accessor issues aligned whole-word transfers only
// RULE_09 - multi-word transfers complete without interruption
// RULE_10 - concurrent source requests behave sequentially
// RULE_11 - mask load leaves mask unchanged
// RULE_12 - summary load clears the words read
// RULE_13 - mask store overwrites addressed word
// RULE_14 - summary store ors data into word
// RULE_15 - request re-evaluated after every store
// RULE_16 - sources never drop needed requests
// RULE_17 - sources avoid redundant submissions while pending
// RULE_18 - selector load returns bits 26 to 31
// RULE_19 - selector store takes bits 26 to 31
// RULE_20 - source sets summary bit its selector names
// RULE_21 - timer is a source, selector at 20
// RULE_22 - no priority among summary bits
// RULE_23 - low word holds bits 0 to 31
module ext_irq_mask_summary (
  // clock and reset
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_b_i,
  // processor state
  input  wire logic                   external_enable_bit_i,
  // load/store word port
  input  wire logic                   acc_valid_i,
  input  wire logic                   acc_write_i,
  input  wire logic                   acc_last_i,
  input  wire logic                   acc_seg_io_i,
  input  wire logic                   acc_seg_key_i,
  input  wire logic [7:0]             acc_bus_unit_id_i,
  input  wire logic [19:0]            acc_seg_adapter_i,
  input  wire ext_irq_pkg::io_addr_t  acc_addr_i,
  input  wire ext_irq_pkg::word_t     acc_wdata_i,
  // load/store answer
  output logic                        rsp_valid_o,
  output ext_irq_pkg::word_t          rsp_rdata_o,
  output logic                        rsp_exc_o,
  // interrupt sources
  input  wire logic [`EXT_SRC_COUNT-1:0] ext_src_i,
  input  wire logic                   timer_evt_i,
  // interrupt request
  output logic                        processor_irq_request_o,
  output logic                        combined_masked_request_o
);
  import ext_irq_pkg::*;

  // link to the per-source selector bank
  sel_map_if map_bus ();

  // registered state, plus the combinational summary next-state and update vectors
  vec64_t      request_mask_reg;
  vec64_t      pending_summary_reg;
  vec64_t      pending_summary_next;
  vec64_t      clr_vec;
  vec64_t      or_vec;
  acc_state_t  acc_state_reg;
  logic        rsp_valid_reg;
  word_t       rsp_rdata_reg;
  logic        rsp_exc_reg;
  logic        irq_reg;
  logic        combined_reg;

  // decode and datapath
  wire  [`EXT_SRC_COUNT-1:0] src_edge;
  logic                    seg_ok;
  logic                    dec_exc;
  logic                    dec_mask;
  logic                    dec_sum;
  logic                    dec_sel;
  logic [`SRC_IDX_W-1:0]   dec_idx;
  logic                    word_hi;
  logic                    take;
  logic                    fault;
  word_t                   rd_word;
  io_addr_t                sel_off;
  logic                    combined_now;

  source_mapper u_mapper (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .map_io     (map_bus.map)
  );

  // per-pin two-flop synchroniser and rising-edge detect
  genvar s;
  generate
    for (s = 0; s < `EXT_SRC_COUNT; s++) begin : g_pin
      logic meta_reg;
      logic sync_reg;
      logic prev_reg;

      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= ext_src_i[s];
          sync_reg <= meta_reg;
        end
      end

      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          prev_reg <= 1'b0;
        end else begin
          prev_reg <= sync_reg;
        end
      end

      assign src_edge[s] = sync_reg & ~prev_reg;
    end
  endgenerate

  // one event per pin rising edge; timer level drives source zero each cycle it is high
  always_comb begin
    map_bus.src_evt = '0;
    map_bus.src_evt[`TIMER_SRC_IDX] = timer_evt_i; // RULE_21
    for (int i = 0; i < `EXT_SRC_COUNT; i++) begin
      map_bus.src_evt[i + `EXT_SRC_IDX0] = src_edge[i];
    end
  end

  // segment and address decode
  always_comb begin
    seg_ok   = (acc_seg_io_i == `SEG_IO_SPACE) &&
               (acc_bus_unit_id_i == `BUS_UNIT_ZERO) &&
               (acc_seg_adapter_i == `ADAPTER_ZERO);
    dec_exc  = 1'b0;
    dec_mask = 1'b0;
    dec_sum  = 1'b0;
    dec_sel  = 1'b0;
    dec_idx  = `TIMER_SRC_IDX;
    sel_off  = acc_addr_i - `OFF_SRC_SEL_BASE;
    if (!seg_ok) begin
      dec_exc = 1'b1; // RULE_06
    end else if (acc_seg_key_i == `SEG_KEY_PRIV) begin
      dec_exc = 1'b1; // RULE_06
    end else if (acc_addr_i[`ADDR_ALIGN_HI:`ADDR_ALIGN_LO] != 2'h0) begin
      dec_exc = 1'b1;
    end else if (acc_addr_i == `OFF_MASK_LO || acc_addr_i == `OFF_MASK_HI) begin
      dec_mask = 1'b1;
    end else if (acc_addr_i == `OFF_SUM_LO || acc_addr_i == `OFF_SUM_HI) begin
      dec_sum = 1'b1;
    end else if (acc_addr_i == `OFF_TIMER_SEL) begin
      dec_sel = 1'b1; // RULE_21
    end else if (acc_addr_i >= `OFF_SRC_SEL_BASE && acc_addr_i < `OFF_SRC_SEL_END) begin
      dec_sel = 1'b1;
      dec_idx = `SRC_IDX_W'(sel_off >> `ADDR_IDX_SHIFT) + `EXT_SRC_IDX0;
    end else begin
      dec_exc = 1'b1; // RULE_07
    end
  end

  // word select and access qualifiers
  assign word_hi = acc_addr_i[`ADDR_WORD_BIT]; // RULE_23
  assign fault   = dec_exc | (acc_state_reg == ACC_ABORT);
  assign take    = acc_valid_i & ~fault;

  // selector write strobes
  always_comb begin
    map_bus.sel_wr    = '0;
    map_bus.sel_wdata = acc_wdata_i[`SEL_FIELD_HI:`SEL_FIELD_LO]; // RULE_19
    if (take && dec_sel && acc_write_i) begin
      map_bus.sel_wr[dec_idx] = 1'b1; // RULE_19
    end
  end

  // summary clear on load
  always_comb begin
    clr_vec = '0;
    if (take && dec_sum && !acc_write_i) begin
      clr_vec[word_hi * `WORD_BITS +: `WORD_BITS] = '1; // RULE_12
    end
  end

  // summary set on store
  always_comb begin
    or_vec = '0;
    if (take && dec_sum && acc_write_i) begin
      or_vec[word_hi * `WORD_BITS +: `WORD_BITS] = acc_wdata_i; // RULE_14
    end
  end

  // read happens first, then stores and source sets land on top
  always_comb begin
    pending_summary_next = (pending_summary_reg & ~clr_vec) | or_vec |
                           map_bus.set_vec; // RULE_04 RULE_10
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pending_summary_reg <= '0;
    end else begin
      pending_summary_reg <= pending_summary_next; // RULE_02
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      request_mask_reg <= '0;
    end else if (take && dec_mask && acc_write_i) begin
      request_mask_reg[word_hi * `WORD_BITS +: `WORD_BITS] <= acc_wdata_i; // RULE_13
    end
  end

  // read data mux
  always_comb begin
    rd_word = '0;
    if (dec_mask) begin
      rd_word = request_mask_reg[word_hi * `WORD_BITS +: `WORD_BITS]; // RULE_11
    end else if (dec_sum) begin
      rd_word = pending_summary_reg[word_hi * `WORD_BITS +: `WORD_BITS]; // RULE_12
    end else if (dec_sel) begin
      rd_word = {{`SEL_PAD_W{1'b0}}, map_bus.sel_rdata[dec_idx]}; // RULE_18
    end
  end

  // transfer state: a faulted transfer is dropped to its last word
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_state_reg <= ACC_IDLE;
    end else if (acc_valid_i) begin
      if (acc_last_i) begin
        acc_state_reg <= ACC_IDLE;
      end else if (fault) begin
        acc_state_reg <= ACC_ABORT; // RULE_07
      end else begin
        acc_state_reg <= ACC_BURST; // RULE_09
      end
    end
  end

  // answer strobe
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rsp_valid_reg <= 1'b0;
    end else begin
      rsp_valid_reg <= acc_valid_i;
    end
  end

  // answer fault flag
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rsp_exc_reg <= 1'b0;
    end else begin
      rsp_exc_reg <= acc_valid_i & fault; // RULE_06 RULE_07
    end
  end

  // answer data, zero unless a good load
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rsp_rdata_reg <= '0;
    end else if (take && !acc_write_i) begin
      rsp_rdata_reg <= rd_word;
    end else begin
      rsp_rdata_reg <= '0;
    end
  end

  // or of all unmasked pending bits, no priority
  assign combined_now = |(request_mask_reg & pending_summary_reg); // RULE_03 RULE_05 RULE_22

  // combined request, registered
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      combined_reg <= 1'b0;
    end else begin
      combined_reg <= combined_now; // RULE_15
    end
  end

  // request held steady inside a multi-word transfer
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_reg <= 1'b0;
    end else if (acc_state_reg == ACC_IDLE) begin
      irq_reg <= external_enable_bit_i & combined_now; // RULE_01 RULE_15
    end else begin
      irq_reg <= irq_reg; // RULE_09
    end
  end

  assign rsp_valid_o               = rsp_valid_reg;
  assign rsp_rdata_o               = rsp_rdata_reg;
  assign rsp_exc_o                 = rsp_exc_reg;
  assign processor_irq_request_o   = irq_reg;
  assign combined_masked_request_o = combined_reg;

endmodule : ext_irq_mask_summary

// *** test/ext_irq_mask_summary_props.sv ***
`timescale 1ns/100ps
module ext_irq_mask_summary_props (
  // clock and reset
  input wire logic                  core_clk_i,
  input wire logic                  rst_b_i,
  // watched ports
  input wire logic                  external_enable_bit_i,
  input wire logic                  acc_valid_i,
  input wire logic                  acc_write_i,
  input wire logic                  acc_seg_io_i,
  input wire logic                  acc_seg_key_i,
  input wire ext_irq_pkg::io_addr_t acc_addr_i,
  input wire logic                  rsp_valid_o,
  input wire ext_irq_pkg::word_t    rsp_rdata_o,
  input wire logic                  rsp_exc_o,
  input wire logic                  processor_irq_request_o
);
  import ext_irq_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  chk_rsp_next: assert property (acc_valid_i |=> rsp_valid_o)
    else $error("answer missing");
  chk_rsp_cause: assert property (rsp_valid_o |-> $past(acc_valid_i))
    else $error("answer without access");
  chk_irq_enable: assert property ($rose(processor_irq_request_o) |-> $past(external_enable_bit_i))
    else $error("irq while disabled");
  chk_key_fault: assert property (acc_valid_i && acc_seg_key_i |=> rsp_exc_o)
    else $error("key access not refused");
  chk_seg_fault: assert property (acc_valid_i && !acc_seg_io_i |=> rsp_exc_o)
    else $error("non io access not refused");
  chk_rsvd_fault: assert property (acc_valid_i && acc_addr_i inside {28'h8, 28'hc, 28'h18, 28'h1c}
    |=> rsp_exc_o)
    else $error("reserved access not refused");
  chk_align_fault: assert property (acc_valid_i && acc_addr_i[1:0] != 2'h0 |=> rsp_exc_o)
    else $error("unaligned access not refused");
  chk_exc_no_data: assert property (rsp_exc_o |-> rsp_valid_o && rsp_rdata_o == 32'h0)
    else $error("faulted word carried data");
  chk_sel_upper: assert property (rsp_valid_o && !rsp_exc_o && $past(acc_addr_i) == 28'h20
    && !$past(acc_write_i) |-> rsp_rdata_o[31:6] == 26'h0)
    else $error("selector load upper bits");
endmodule : ext_irq_mask_summary_props

bind ext_irq_mask_summary ext_irq_mask_summary_props props_i (.*);

// *** test/host_port_model.sv ***
`timescale 1ns/100ps
module host_port_model (
  // clock
  input  wire logic                core_clk_i,
  // load/store path
  output logic                     acc_valid_i,
  output logic                     acc_write_i,
  output logic                     acc_last_i,
  output logic                     acc_seg_io_i,
  output logic                     acc_seg_key_i,
  output logic [7:0]               acc_bus_unit_id_i,
  output logic [19:0]              acc_seg_adapter_i,
  output ext_irq_pkg::io_addr_t    acc_addr_i,
  output ext_irq_pkg::word_t       acc_wdata_i,
  input  wire ext_irq_pkg::word_t  rsp_rdata_o,
  input  wire logic                rsp_exc_o,
  // sources
  output logic [3:0]               ext_src_i,
  output logic                     timer_evt_i
);
  import ext_irq_pkg::*;
  initial begin
    {acc_valid_i, acc_write_i, acc_last_i, acc_seg_key_i, ext_src_i, timer_evt_i} = '0;
    acc_seg_io_i = 1'b1;
    acc_bus_unit_id_i = 8'h00;
    acc_seg_adapter_i = 20'h00000;
    acc_addr_i = 28'h0;
    acc_wdata_i = 32'h0;
  end
  // one word, answer taken one edge later
  task xfer(input logic w, input io_addr_t a, input word_t d, input logic last,
            input logic key, output word_t rd, output logic exc);
    @(negedge core_clk_i);
    acc_valid_i = 1'b1;
    acc_write_i = w;
    acc_addr_i = a;
    acc_wdata_i = d;
    acc_last_i = last;
    acc_seg_key_i = key;
    @(negedge core_clk_i);
    rd = rsp_rdata_o;
    exc = rsp_exc_o;
    acc_valid_i = 1'b0;
    acc_addr_i = ~a;
    acc_wdata_i = ~d;
  endtask : xfer
  task timer_pulse;
    @(negedge core_clk_i);
    timer_evt_i = 1'b1;
    @(negedge core_clk_i);
    timer_evt_i = 1'b0;
  endtask : timer_pulse
  task ext_pulse(input int i);
    @(negedge core_clk_i);
    ext_src_i[i] = 1'b1;
    repeat (4) @(negedge core_clk_i);
    ext_src_i[i] = 1'b0;
  endtask : ext_pulse
endmodule : host_port_model

// *** test/ext_irq_mask_summary_test.sv ***
`timescale 1ns/100ps
module ext_irq_mask_summary_test;
  import ext_irq_pkg::*;
  logic       core_clk_i, rst_b_i, external_enable_bit_i, acc_valid_i, acc_write_i;
  logic       acc_last_i, acc_seg_io_i, acc_seg_key_i, rsp_valid_o, rsp_exc_o, timer_evt_i;
  logic       processor_irq_request_o, combined_masked_request_o, ex;
  logic [7:0] acc_bus_unit_id_i;
  logic [19:0] acc_seg_adapter_i;
  logic [3:0] ext_src_i;
  io_addr_t   acc_addr_i;
  word_t      acc_wdata_i, rsp_rdata_o, rd, r2;
  int         fails, checked;
  ext_irq_mask_summary ext_irq_mask_summary_i (.*);
  host_port_model host_port_model_i (.*);
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  task chk(input word_t seen, input word_t exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task acc(input logic w, input io_addr_t a, input word_t d);
    host_port_model_i.xfer(w, a, d, 1'b1, 1'b0, rd, ex);
  endtask : acc
  task waitn(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : waitn
  task final_report;
    if (fails == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  initial begin
    #20000;
    fails++;
    final_report;
  end
  initial begin
    rst_b_i = 1'b0;
    external_enable_bit_i = 1'b0;
    waitn(10);
    rst_b_i = 1'b1;
    acc(1, 28'h0, 32'ha5a5_0f0f);
    acc(1, 28'h4, 32'h0);
    acc(0, 28'h0, 32'h0);
    chk(rd, 32'ha5a5_0f0f);
    acc(0, 28'h0, 32'h0);
    chk(rd, 32'ha5a5_0f0f);
    acc(1, 28'h10, 32'h0000_00f0);
    acc(1, 28'h10, 32'h0000_000f);
    acc(0, 28'h10, 32'h0);
    chk(rd, 32'h0000_00ff);
    acc(0, 28'h10, 32'h0);
    chk(rd, 32'h0);
    acc(1, 28'h20, 32'hffff_ffe5);
    acc(0, 28'h20, 32'h0);
    chk(rd, 32'h25);
    host_port_model_i.timer_pulse;
    waitn(4);
    chk({31'h0, combined_masked_request_o}, 32'h0);
    acc(1, 28'h4, 32'h0400_0000);
    external_enable_bit_i = 1'b1;
    waitn(3);
    chk({31'h0, combined_masked_request_o}, 32'h1);
    chk({31'h0, processor_irq_request_o}, 32'h1);
    external_enable_bit_i = 1'b0;
    waitn(3);
    chk({31'h0, processor_irq_request_o}, 32'h0);
    acc(0, 28'h14, 32'h0);
    chk(rd, 32'h0400_0000);
    waitn(3);
    chk({31'h0, combined_masked_request_o}, 32'h0);
    acc(1, 28'h40, 32'h3);
    host_port_model_i.ext_pulse(0);
    waitn(4);
    acc(0, 28'h10, 32'h0);
    chk(rd, 32'h1000_0000);
    host_port_model_i.xfer(1, 28'h0, 32'h0, 1'b1, 1'b1, rd, ex);
    chk({31'h0, ex}, 32'h1);
    acc(0, 28'h0, 32'h0);
    chk(rd, 32'ha5a5_0f0f);
    host_port_model_i.xfer(1, 28'h4, 32'h1234_5678, 1'b0, 1'b0, rd, ex);
    host_port_model_i.xfer(1, 28'h8, 32'hffff_ffff, 1'b1, 1'b0, rd, ex);
    chk({31'h0, ex}, 32'h1);
    acc(0, 28'h4, 32'h0);
    chk(rd, 32'h1234_5678);
    acc(0, 28'h2, 32'h0);
    chk({31'h0, ex}, 32'h1);
    acc(1, 28'h20, 32'h0);
    fork
      host_port_model_i.timer_pulse;
      host_port_model_i.xfer(0, 28'h10, 32'h0, 1'b0, 1'b0, r2, ex);
    join
    chk({31'h0, ex}, 32'h0);
    host_port_model_i.xfer(0, 28'h14, 32'h0, 1'b1, 1'b0, rd, ex);
    acc(0, 28'h10, 32'h0);
    chk(rd | r2, 32'h8000_0000);
    // mid-run reset returns mask and selectors to zero
    rst_b_i = 1'b0;
    waitn(2);
    rst_b_i = 1'b1;
    acc(0, 28'h4, 32'h0);
    chk(rd, 32'h0);
    acc(0, 28'h20, 32'h0);
    chk(rd, 32'h0);
    final_report;
  end
endmodule : ext_irq_mask_summary_test
